/* File: wake_pkg.sv */
// constants for the receive wake configuration block
package wake_pkg;
   localparam int          ADDR_W            = 12;
   // register indices; the bus byte address is four times the index
   localparam logic [11:0] IDX_CFG           = 12'h134;
   localparam logic [11:0] IDX_STS           = 12'h135;
   localparam logic [11:0] IDX_PW0           = 12'h139;
   localparam logic [11:0] IDX_PW1           = 12'h13A;
   localparam logic [11:0] IDX_PW2           = 12'h13B;
   localparam logic [11:0] IDX_IRQ_STS       = 12'h141;
   localparam logic [11:0] IDX_IRQ_EN        = 12'h142;
   localparam logic [11:0] IDX_IRQ_CLR       = 12'h143;
   // configuration field positions
   localparam int          B_MAGIC           = 0;
   localparam int          B_PATTERN         = 1;
   localparam int          B_BCAST           = 2;
   localparam int          B_UCAST           = 4;
   localparam int          B_PWCHK           = 5;
   localparam int          B_FEATURE         = 7;
   localparam int          B_STYLE           = 8;
   localparam int          B_WIDTH_LO        = 9;
   localparam int          B_CLEAR           = 11;
   localparam logic [15:0] CFG_RESET         = 16'h0004;
   localparam logic [15:0] CFG_WMASK         = 16'h0FB7;
   // status field positions
   localparam int          S_MAGIC           = 0;
   localparam int          S_PATTERN         = 1;
   localparam int          S_BCAST           = 2;
   localparam int          S_UCAST           = 4;
   localparam int          S_HACK            = 5;
   localparam int          S_CRC             = 6;
   localparam int          S_SFD             = 7;
   localparam logic [7:0]  STS_MASK          = 8'hF7;
   // pulse widths in 125-MHz cycles, scaled to the 250-MHz system clock
   localparam int          CLK_MHZ           = 250;
   localparam int          WAKE_CLK_MHZ      = 125;
   localparam int          PULSE_BASE_CYC    = 8;
   localparam int          PULSE_SCALE       = CLK_MHZ / WAKE_CLK_MHZ;
   localparam logic [1:0]  RESP_OKAY         = 2'b00;
   localparam logic [1:0]  RESP_SLVERR       = 2'b10;
   localparam logic [31:0] IRQ_RESET         = 32'h0000_0000;
endpackage

/* File: wake_pulse_gen.sv */
// wake output generator: pulse of selectable length or held level
`timescale 1ns/1ps
`default_nettype none
module wake_pulse_gen
   import wake_pkg::*;
(
   input  wire logic       clk_sys,    // system clock
   input  wire logic       srst,       // sync reset
   input  wire logic       trig,       // one wake event
   input  wire logic       levelStyle, // 1 level, 0 pulse
   input  wire logic [1:0] widthSel,   // pulse width select
   input  wire logic       clearLevel, // software clear of level
   output logic            wakeOut     // wake output
);
   logic [8:0] cnt;
   logic [8:0] pulseLen;

   // 8/16/32/64 wake cycles, two system cycles each
   assign pulseLen = 9'((PULSE_BASE_CYC * PULSE_SCALE) << widthSel);

   // a new event restarts the pulse rather than queuing a second one
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt     <= '0;
         wakeOut <= 1'b0;
      end else if (trig) begin
         wakeOut <= 1'b1;
         cnt     <= levelStyle ? 9'h000 : pulseLen - 9'h001;
      end else if (levelStyle) begin
         if (clearLevel) wakeOut <= 1'b0;
      end else if (cnt != 9'h000) begin
         cnt <= cnt - 9'h001;
      end else begin
         wakeOut <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: wake_on_lan_rx_config.sv */
// receive wake configuration register bank with AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wake_on_lan_rx_config
   import wake_pkg::*;
(
   input  wire logic        clk_sys,       // system clock
   input  wire logic        srst,          // sync reset
   // axi4-lite slave
   input  wire logic [13:0] s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [13:0] s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read valid
   input  wire logic        s_axi_rready,  // read ready
   // receive detector events, one-cycle pulses
   input  wire logic        evMagic,       // magic packet seen
   input  wire logic [47:0] evMagicPass,   // password carried by that packet
   input  wire logic        evPattern,     // pattern match
   input  wire logic        evBcast,       // broadcast packet
   input  wire logic        evUcast,       // unicast packet
   input  wire logic        evBadCrc,      // bad crc
   input  wire logic        evSfdErr,      // sfd error
   // controls to the receive path
   output logic             rxFeatureOn,   // enhanced receive features on
   output logic             crcCheckOn,    // crc checking on
   output logic             tsIndicateOn,  // timestamp indication on
   output logic             wakeOut,       // wake output
   output logic             irq            // interrupt, level
);
   logic [15:0] cfg;
   logic [7:0]  rxStatus;
   logic [47:0] password;
   logic [7:0]  irqSts;
   logic [7:0]  irqEn;
   logic        awHeld;
   logic        wHeld;
   logic [11:0] awIdx;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        doWrite;
   logic        doRead;
   logic [11:0] arIdx;
   logic [7:0]  evVec;
   logic [7:0]  next_rxStatus;
   logic        magicOk;
   logic        wakeTrig;
   logic        clearPulse;
   logic        stsReadHit;
   logic [31:0] next_rdata;
   logic        rdMapped;
   logic        wrMapped;
   logic [7:0]  irqClrVec;
   logic [7:0]  next_irqSts;

   // registered aliases of the feature enable
   assign rxFeatureOn  = cfg[B_FEATURE];
   assign crcCheckOn   = cfg[B_FEATURE];
   assign tsIndicateOn = cfg[B_FEATURE];

   // ---- write channel: address and data taken in either order
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;
   assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         awHeld <= 1'b0;
         awIdx  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld <= 1'b1;
         awIdx  <= s_axi_awaddr[13:2];
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wHeld <= 1'b0;
         wData <= '0;
         wStrb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld <= 1'b1;
         wData <= s_axi_wdata;
         wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   // only registers software may write are mapped for writes
   always_comb begin
      case (awIdx)
         IDX_CFG, IDX_PW0, IDX_PW1, IDX_PW2, IDX_IRQ_EN, IDX_IRQ_CLR: wrMapped = 1'b1;
         default: wrMapped = 1'b0;
      endcase
   end

   // write response
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // clear strobe lasts the write cycle, the stored bit never reads back as one
   assign clearPulse = doWrite && awIdx == IDX_CFG && wStrb[1] && wData[B_CLEAR];

   // configuration register, byte lanes honoured; clear bit self-clears
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cfg <= CFG_RESET;
      end else if (doWrite && awIdx == IDX_CFG) begin
         if (wStrb[0]) cfg[7:0]  <= wData[7:0] & CFG_WMASK[7:0];
         if (wStrb[1]) cfg[15:8] <= wData[15:8] & CFG_WMASK[15:8] & 8'hF7;
      end
   end

   // password in three 16-bit words
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         password <= '0;
      end else if (doWrite) begin
         for (int i = 0; i < 3; i++) begin
            if (awIdx == IDX_PW0 + 12'(i)) begin
               if (wStrb[0]) password[16*i +: 8]     <= wData[7:0];
               if (wStrb[1]) password[16*i + 8 +: 8] <= wData[15:8];
            end
         end
      end
   end

   // ---- event qualification
   // a magic packet with the wrong password counts as a hack attempt, not a wake
   assign magicOk = evMagic && (!cfg[B_PWCHK] || evMagicPass == password);

   always_comb begin
      evVec            = '0;
      evVec[S_MAGIC]   = magicOk;
      evVec[S_PATTERN] = evPattern;
      evVec[S_BCAST]   = evBcast;
      evVec[S_UCAST]   = evUcast;
      evVec[S_HACK]    = evMagic && cfg[B_PWCHK] && !magicOk;
      evVec[S_CRC]     = evBadCrc;
      evVec[S_SFD]     = evSfdErr;
      evVec            = evVec & {8{cfg[B_FEATURE]}};
   end

   // any enabled event in a cycle gives one trigger
   assign wakeTrig = cfg[B_FEATURE] && (
      (evVec[S_MAGIC]   && cfg[B_MAGIC])   ||
      (evVec[S_PATTERN] && cfg[B_PATTERN]) ||
      (evVec[S_BCAST]   && cfg[B_BCAST])   ||
      (evVec[S_UCAST]   && cfg[B_UCAST]));

   // ---- read channel: one read at a time, answered the cycle after acceptance
   assign s_axi_arready = !s_axi_rvalid;
   assign doRead        = s_axi_arvalid && s_axi_arready;
   assign arIdx         = s_axi_araddr[13:2];
   assign stsReadHit    = doRead && arIdx == IDX_STS;

   // status latches high, cleared by read; a same-cycle event survives
   always_comb begin
      next_rxStatus = stsReadHit ? 8'h00 : rxStatus;
      next_rxStatus = (next_rxStatus | evVec) & STS_MASK;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) rxStatus <= '0;
      else      rxStatus <= next_rxStatus;
   end

   // interrupt status: set wins over write-one-to-clear
   assign irqClrVec = (doWrite && awIdx == IDX_IRQ_CLR && wStrb[0]) ? wData[7:0] : 8'h00;

   assign next_irqSts = ((irqSts & ~irqClrVec) | evVec) & STS_MASK;

   always_ff @(posedge clk_sys) begin
      if (srst) irqSts <= '0;
      else      irqSts <= next_irqSts;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) irqEn <= '0;
      else if (doWrite && awIdx == IDX_IRQ_EN && wStrb[0]) irqEn <= wData[7:0] & STS_MASK;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) irq <= 1'b0;
      else      irq <= |(next_irqSts & irqEn); // follows the status being stored
   end

   // read mux; the password reads back as written
   always_comb begin
      rdMapped   = 1'b1;
      next_rdata = '0;
      case (arIdx)
         IDX_CFG:     next_rdata = {16'h0000, cfg};
         IDX_STS:     next_rdata = {24'h000000, rxStatus};
         IDX_PW0:     next_rdata = {16'h0000, password[15:0]};
         IDX_PW1:     next_rdata = {16'h0000, password[31:16]};
         IDX_PW2:     next_rdata = {16'h0000, password[47:32]};
         IDX_IRQ_STS: next_rdata = {24'h000000, irqSts};
         IDX_IRQ_EN:  next_rdata = {24'h000000, irqEn};
         IDX_IRQ_CLR: next_rdata = '0;
         default:     rdMapped   = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (doRead) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---- wake output
   wake_pulse_gen u_pulse (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .trig       (wakeTrig),
      .levelStyle (cfg[B_STYLE]),
      .widthSel   (cfg[B_WIDTH_LO +: 2]),
      .clearLevel (clearPulse),
      .wakeOut    (wakeOut)
   );
endmodule
`default_nettype wire

/* File: wake_checker.sv */
// port checks for the receive wake block
`timescale 1ns/1ps
`default_nettype none
module wake_checker (
   input  wire logic        clk_sys,       // clock
   input  wire logic        srst,          // reset
   input  wire logic        s_axi_awready, // aw ready
   input  wire logic        s_axi_wready,  // w ready
   input  wire logic        s_axi_bvalid,  // b valid
   input  wire logic        s_axi_bready,  // b ready
   input  wire logic        s_axi_arready, // ar ready
   input  wire logic [31:0] s_axi_rdata,   // r data
   input  wire logic        s_axi_rvalid,  // r valid
   input  wire logic        s_axi_rready,  // r ready
   input  wire logic        evMagic,       // magic
   input  wire logic        evPattern,     // pattern
   input  wire logic        evBcast,       // broadcast
   input  wire logic        evUcast,       // unicast
   input  wire logic        rxFeatureOn,   // feature
   input  wire logic        crcCheckOn,    // crc on
   input  wire logic        tsIndicateOn,  // timestamp on
   input  wire logic        wakeOut,       // wake
   input  wire logic        irq            // interrupt
);
   logic [7:0] hiCnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // length of the current wake assertion, saturating so levels never wrap
   always_ff @(posedge clk_sys) begin
      if (srst || !wakeOut) begin
         hiCnt <= 8'h00;
      end else if (hiCnt != 8'hFF) begin
         hiCnt <= hiCnt + 8'h01;
      end
   end
   property p_feat; rxFeatureOn == crcCheckOn && rxFeatureOn == tsIndicateOn; endproperty
   a_feat: assert property (p_feat) else $error("feature outputs differ");
   property p_off; !rxFeatureOn && !wakeOut |=> !wakeOut; endproperty
   a_off: assert property (p_off) else $error("wake with features off");
   property p_cause; $rose(wakeOut) |-> $past(evMagic || evPattern || evBcast || evUcast); endproperty
   a_cause: assert property (p_cause) else $error("wake without event");
   // a short fall is only legal at a software clear
   property p_fall; $fell(wakeOut) |-> hiCnt >= 8'h10 || $rose(s_axi_bvalid); endproperty
   a_fall: assert property (p_fall) else $error("wake pulse too short");
   property p_bref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_bref: assert property (p_bref) else $error("write taken during response");
   property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rref: assert property (p_rref) else $error("read taken during response");
   property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bdrop: assert property (p_bdrop) else $error("write response repeated");
   property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rdrop: assert property (p_rdrop) else $error("read response repeated");
   property p_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read data not zero");
   c_wake: cover property ($rose(wakeOut));
   c_irq: cover property ($rose(irq));
   c_level: cover property (wakeOut && hiCnt == 8'hFF);
endmodule
`default_nettype wire

/* File: wake_watch.sv */
// wake controller model: times each wake assertion
`timescale 1ns/1ps
`default_nettype none
module wake_watch (
   input  wire logic       clk_sys,   // clock
   input  wire logic       srst,      // reset
   input  wire logic       wakeIn,    // wake line
   output logic      [7:0] lastWidth, // last high length
   output logic      [7:0] wakeCount  // assertions seen
);
   logic [7:0] hiCnt;
   // length booked at the fall; saturates on long levels
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hiCnt <= 8'h00;
         lastWidth <= 8'h00;
         wakeCount <= 8'h00;
      end else if (wakeIn) begin
         hiCnt <= (hiCnt == 8'hFF) ? hiCnt : hiCnt + 8'h01;
         if (hiCnt == 8'h00) wakeCount <= wakeCount + 8'h01;
      end else if (hiCnt != 8'h00) begin
         lastWidth <= hiCnt;
         hiCnt <= 8'h00;
      end
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the receive wake block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import wake_pkg::*;
   logic        clk_sys = 1'b0, srst = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rs = 32'hBBA6BB76;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        evMagic = 1'b0, evPattern = 1'b0, evBcast = 1'b0, evUcast = 1'b0;
   logic        evBadCrc = 1'b0, evSfdErr = 1'b0;
   logic [47:0] evMagicPass = 48'h0, pw;
   logic        rxFeatureOn, crcCheckOn, tsIndicateOn, wakeOut, irq;
   logic [7:0]  lastWidth, wakeCount, m, c0;
   int          err_total = 0, cmp_count = 0, k;
   // 250 MHz system clock
   always #2 clk_sys = ~clk_sys;
   wake_on_lan_rx_config u_dut (.*, .s_axi_wstrb(4'hF), .s_axi_bready(1'b1),
      .s_axi_rready(1'b1));
   wake_watch u_far (.clk_sys(clk_sys), .srst(srst), .wakeIn(wakeOut),
      .lastWidth(lastWidth), .wakeCount(wakeCount));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ready sampled at the falling edge is what the next rising edge sees
   task automatic wr(input logic [11:0] idx, input logic [15:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge clk_sys);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk_sys);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) return;
      end
      chk("write timeout", 0, 1);
      close_out();
   endtask
   task automatic rdr(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic ta, tb;
      @(posedge clk_sys);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk_sys);
         ta = s_axi_arvalid & s_axi_arready;
         tb = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_sys);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tb) return;
      end
      chk("read timeout", 0, 1);
      close_out();
   endtask
   task automatic rc(input string nm, input logic [11:0] idx, input logic [31:0] exp);
      rdr(idx, rd, rr);
      chk(nm, rd, exp);
   endtask
   // one-cycle event pulse; mask bits follow the status layout
   task automatic fire(input logic [7:0] e, input logic [47:0] p);
      @(posedge clk_sys);
      {evSfdErr, evBadCrc, evUcast, evBcast, evPattern, evMagic} <= {e[7:6], e[4], e[2:0]};
      evMagicPass <= p;
      @(posedge clk_sys);
      {evSfdErr, evBadCrc, evUcast, evBcast, evPattern, evMagic} <= 6'h00;
   endtask
   task automatic wait_low();
      for (int n = 0; n < 300; n++) begin
         @(negedge clk_sys);
         if (!wakeOut) begin
            @(negedge clk_sys);
            return;
         end
      end
      chk("wake timeout", 0, 1);
      close_out();
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      rc("cfg reset", IDX_CFG, 32'h0004);
      chk("feature off", {crcCheckOn, tsIndicateOn, rxFeatureOn}, 0);
      rdr(12'h100, rd, rr);
      chk("unmapped rresp", rr, 2);
      wr(12'h100, 16'hFFFF, rr);
      chk("unmapped bresp", rr, 2);
      fire(8'hD7, 48'h0);
      repeat (2) @(negedge clk_sys);
      chk("wake while off", wakeOut, 0);
      rc("status while off", IDX_STS, 0);
      $display("test reset done");
      // two system cycles per 125-MHz cycle
      for (k = 0; k < 4; k++) begin
         wr(IDX_CFG, 16'h0084 | 16'(k << 9), rr);
         chk("feature on", {crcCheckOn, tsIndicateOn, rxFeatureOn}, 7);
         fire(8'h04, 48'h0);
         wait_low();
         chk("pulse width", lastWidth, (8 << k) * 2);
         rc("status bcast", IDX_STS, 32'h4);
         rc("status cleared", IDX_STS, 0);
      end
      $display("test widths done");
      // magic, pattern, broadcast and unicast events each masked, then enabled, with random passwords
      // c0 holds the flag left latched by the previous enabled event
      c0 = 8'h00;
      for (k = 0; k < 4; k++) begin
         m = 8'h01 << ((k == 3) ? 4 : k);
         rs = lfsr(rs);
         wr(IDX_CFG, 16'h0080, rr);
         fire(m, {rs[15:0], rs});
         repeat (2) @(negedge clk_sys);
         chk("masked wake", wakeOut, 0);
         rc("masked status", IDX_STS, m | c0);
         wr(IDX_CFG, {8'h00, 8'h80 | m}, rr);
         fire(m, {rs, rs[15:0]});
         @(negedge clk_sys);
         chk("enabled wake", wakeOut, 1);
         wait_low();
         c0 = m;
      end
      rc("status again", IDX_STS, m);
      wr(IDX_CFG, 16'h0097, rr);
      c0 = wakeCount;
      fire(8'hD6, 48'h0);
      wr(IDX_CFG, 16'h0897, rr);
      chk("clear in pulse style", wakeOut, 1);
      wait_low();
      chk("one wake", wakeCount - c0, 1);
      chk("coincident width", lastWidth, 16);
      rc("all flags", IDX_STS, 32'hD6);
      $display("test events done");
      // level outlasts the longest pulse, ends only by software
      wr(IDX_CFG, 16'h0782, rr);
      fire(8'h02, 48'h0);
      repeat (140) @(negedge clk_sys);
      chk("level held", wakeOut, 1);
      wr(IDX_CFG, 16'h0F82, rr);
      chk("level cleared", wakeOut, 0);
      rc("clear bit reads 0", IDX_CFG, 32'h0782);
      rs = lfsr(rs);
      pw = {rs[15:0], lfsr(rs)};
      wr(IDX_PW0, pw[15:0], rr);
      wr(IDX_PW1, pw[31:16], rr);
      wr(IDX_PW2, pw[47:32], rr);
      rc("password word", IDX_PW1, pw[31:16]);
      wr(IDX_CFG, 16'h00A1, rr);
      fire(8'h01, ~pw);
      repeat (2) @(negedge clk_sys);
      chk("wrong password", wakeOut, 0);
      rc("hack flag", IDX_STS, 32'h22);
      fire(8'h01, pw);
      @(negedge clk_sys);
      chk("right password", wakeOut, 1);
      wait_low();
      $display("test level and password done");
      // interrupt raised, cleared, then masked
      wr(IDX_IRQ_CLR, 16'h00FF, rr);
      wr(IDX_IRQ_EN, 16'h0004, rr);
      chk("irq idle", irq, 0);
      wr(IDX_CFG, 16'h0084, rr);
      fire(8'h04, 48'h0);
      repeat (2) @(negedge clk_sys);
      chk("irq raised", irq, 1);
      wr(IDX_IRQ_CLR, 16'h0004, rr);
      chk("irq cleared", irq, 0);
      wr(IDX_IRQ_EN, 16'h0000, rr);
      fire(8'h04, 48'h0);
      repeat (2) @(negedge clk_sys);
      chk("irq masked", irq, 0);
      rc("irq sticky", IDX_IRQ_STS, 32'h4);
      $display("test interrupts done");
      close_out();
   end
endmodule
bind wake_on_lan_rx_config wake_checker u_chk (.*);
`default_nettype wire
